// ==== logic/ccr_pkg.sv ====
// Constants, register map and channel states of the converter control bank.
// Assumes one clock for the lite port and the core side.
package ccr_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int RESP_W = 2;
    // Offset bits decoded; upper address bits are the base address
    localparam int DEC_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [11:0] OFS_CORE_CONTROL = 12'h000;
    localparam logic [11:0] OFS_PIXEL_COUNT = 12'h01C;
    // Double-buffered set, in index order
    localparam int NUM_DB = 10;
    localparam int IDX_FRAME = 0;
    localparam int IDX_UPPER = 1;
    localparam int IDX_LOWER = 2;
    localparam int IDX_ROFS = 3;
    localparam int IDX_GOFS = 4;
    localparam int IDX_BOFS = 5;
    localparam int IDX_COEF_A = 6;
    localparam int IDX_COEF_B = 7;
    localparam int IDX_COEF_C = 8;
    localparam int IDX_COEF_D = 9;
    localparam logic [11:0] OFS_DB [NUM_DB] = '{
        12'h020, 12'h100, 12'h104, 12'h108, 12'h10C,
        12'h110, 12'h114, 12'h118, 12'h11C, 12'h120};
    localparam logic [31:0] MASK_DB [NUM_DB] = '{
        32'h1FFF1FFF, 32'h0000FFFF, 32'h0000FFFF,
        32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'h0003FFFF, 32'h0003FFFF, 32'h0003FFFF, 32'h0003FFFF};
    // Plain build-time defaults: 32x32 frame, 8-bit limits
    localparam logic [31:0] DEF_DB [NUM_DB] = '{
        32'h00200020, 32'h000000FF, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
    // Control bit positions
    localparam int CTL_ENABLE = 0;
    localparam int CTL_COMMIT = 1;
    localparam int CTL_BYPASS = 4;
    localparam int CTL_TPG = 5;
    localparam int CTL_FSYNC_RST = 30;
    localparam int CTL_SRESET = 31;
    localparam logic [31:0] CTL_WR_MASK = 32'hC0000033;
    localparam logic [31:0] CTL_DBG_BITS = 32'h00000030;
    localparam int FDIM_PIX_W = 13;
    localparam int FDIM_LINE_LSB = 16;
    localparam int LIMIT_W = 16;
    localparam int COEF_W = 18;
    // Lite reset is carried by two flops into the core side
    localparam int RST_SYNC_STAGES = 2;
    // Least reset hold the system must give, in cycles
    localparam int RST_HOLD_CYCLES = 32;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_ACCEPT = 2'b01,
        CH_RESP = 2'b10
    } ccr_chan_e;
endpackage

// ==== logic/ccr_control_regs.sv ====
// Control register bank of a colour-space converter behind a lite port.
// Assumes lite port and core share sys_clk_i; frame and pixel events
// arrive as one-cycle pulses already qualified by the stream handshake.
module ccr_control_regs
    import ccr_pkg::*;
#(
    parameter bit HAS_LITE = 1'b1,
    parameter bit HAS_DEBUG = 1'b1,
    parameter logic [31:0] DEF_REGS [NUM_DB] = DEF_DB
)
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic s_axi_aclken_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [ccr_pkg::DATA_W-1:0] s_axi_wdata_i,
    output logic [ccr_pkg::RESP_W-1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [ccr_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [ccr_pkg::RESP_W-1:0] s_axi_rresp_o,
    input wire logic frame_end_i,
    input wire logic frame_busy_i,
    input wire logic pixel_done_i,
    output logic core_reset_o,
    output logic software_enable_o,
    output logic bypass_o,
    output logic test_pattern_o,
    output logic [31:0] frame_dimensions_o,
    output logic [ccr_pkg::LIMIT_W-1:0] output_upper_limit_o,
    output logic [ccr_pkg::LIMIT_W-1:0] output_lower_limit_o,
    output logic [31:0] red_offset_o,
    output logic [31:0] green_offset_o,
    output logic [31:0] blue_offset_o,
    output logic [ccr_pkg::COEF_W-1:0] matrix_coef_first_o,
    output logic [ccr_pkg::COEF_W-1:0] matrix_coef_second_o,
    output logic [ccr_pkg::COEF_W-1:0] matrix_coef_third_o,
    output logic [ccr_pkg::COEF_W-1:0] matrix_coef_fourth_o
);
    import ccr_pkg::*;

    // Debug bits are never stored when debug features are left out
    localparam logic [31:0] CTL_MASK =
        HAS_DEBUG ? CTL_WR_MASK : (CTL_WR_MASK & ~CTL_DBG_BITS);
    localparam logic [31:0] CTL_RST = {31'h0, ~HAS_LITE};

    ccr_chan_e wst_q;
    ccr_chan_e rst_q;
    logic wrdy_q;
    logic bvalid_q;
    logic ardy_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] ctrl_q;
    logic [31:0] proc_q [NUM_DB];
    logic [31:0] act_q [NUM_DB];
    logic [31:0] pix_q;
    logic [RST_SYNC_STAGES-1:0] rsync_q;
    logic core_rst_q;
    logic wr_fire;
    logic rd_fire;
    logic ctrl_hit;
    logic fsr_done;
    logic soft_rst;
    logic [DEC_W-1:0] wr_ofs;
    logic [DEC_W-1:0] rd_ofs;
    logic rd_mapped;

    // Handshakes complete on the edge where ready is high; valid is held
    // gated by enable
    assign wr_fire = (wst_q == CH_ACCEPT) && s_axi_aclken_i;
    assign rd_fire = (rst_q == CH_ACCEPT) && s_axi_aclken_i;
    assign wr_ofs = s_axi_awaddr_i[DEC_W-1:0];
    assign rd_ofs = s_axi_araddr_i[DEC_W-1:0];
    assign ctrl_hit = wr_fire && (wr_ofs == OFS_CORE_CONTROL);
    assign soft_rst = ctrl_q[CTL_SRESET];
    // end of frame, or at once when idle
    assign fsr_done = ctrl_q[CTL_FSYNC_RST] && (frame_end_i || !frame_busy_i);

    // Write channel: address and data taken together
    // sample on edge, reset wins
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            wst_q <= CH_IDLE;
            wrdy_q <= 1'b0;
            bvalid_q <= 1'b0;
        end
        else if (s_axi_aclken_i)
        begin
            case (wst_q)
                CH_IDLE:
                begin
                    if (HAS_LITE && s_axi_awvalid_i && s_axi_wvalid_i)
                    begin
                        wst_q <= CH_ACCEPT;
                        wrdy_q <= 1'b1;
                    end
                end
                CH_ACCEPT:
                begin
                    wst_q <= CH_RESP;
                    wrdy_q <= 1'b0;
                    bvalid_q <= 1'b1;
                end
                CH_RESP:
                begin
                    if (s_axi_bready_i)
                    begin
                        wst_q <= CH_IDLE;
                        bvalid_q <= 1'b0;
                    end
                end
                default:
                begin
                    wst_q <= CH_IDLE;
                    wrdy_q <= 1'b0;
                    bvalid_q <= 1'b0;
                end
            endcase
        end
    end

    // Read data mux; processor set is what software reads back
    // unmapped reads zero
    always_comb
    begin
        rdata_d = '0;
        if (rd_ofs == OFS_CORE_CONTROL)
            rdata_d = ctrl_q;
        if (rd_ofs == OFS_PIXEL_COUNT && HAS_DEBUG)
            rdata_d = pix_q;
        for (int i = 0; i < NUM_DB; i++)
        begin
            if (rd_ofs == OFS_DB[i])
                rdata_d = proc_q[i];
        end
    end

    // Map decoded apart from the mux, so the unmapped check stays honest
    always_comb
    begin
        rd_mapped = (rd_ofs == OFS_CORE_CONTROL);
        rd_mapped = rd_mapped || (rd_ofs == OFS_PIXEL_COUNT);
        for (int i = 0; i < NUM_DB; i++)
            rd_mapped = rd_mapped || (rd_ofs == OFS_DB[i]);
    end

    // Read channel: data captured on the address handshake edge
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rst_q <= CH_IDLE;
            ardy_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
        end
        else if (s_axi_aclken_i)
        begin
            case (rst_q)
                CH_IDLE:
                begin
                    if (HAS_LITE && s_axi_arvalid_i)
                    begin
                        rst_q <= CH_ACCEPT;
                        ardy_q <= 1'b1;
                    end
                end
                CH_ACCEPT:
                begin
                    rst_q <= CH_RESP;
                    ardy_q <= 1'b0;
                    rvalid_q <= 1'b1;
                    rdata_q <= rdata_d;
                end
                CH_RESP:
                begin
                    if (s_axi_rready_i)
                    begin
                        rst_q <= CH_IDLE;
                        rvalid_q <= 1'b0;
                    end
                end
                default:
                begin
                    rst_q <= CH_IDLE;
                    ardy_q <= 1'b0;
                    rvalid_q <= 1'b0;
                end
            endcase
        end
    end

    // Control register; frame-sync bit clears itself, a new set wins
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            ctrl_q <= CTL_RST;
        else
        begin
            if (fsr_done)
                ctrl_q[CTL_FSYNC_RST] <= 1'b0;
            if (ctrl_hit)
                ctrl_q <= s_axi_wdata_i & CTL_MASK;
        end
    end

    // Processor set; soft reset holds it at defaults
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || soft_rst)
        begin
            for (int i = 0; i < NUM_DB; i++)
                proc_q[i] <= DEF_REGS[i] & MASK_DB[i];
        end
        else if (wr_fire)
        begin
            for (int i = 0; i < NUM_DB; i++)
            begin
                if (wr_ofs == OFS_DB[i])
                    proc_q[i] <= s_axi_wdata_i & MASK_DB[i];
            end
        end
    end

    // Active set, updated only on a committed frame boundary; soft reset holds it at defaults
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || soft_rst)
        begin
            for (int i = 0; i < NUM_DB; i++)
                act_q[i] <= DEF_REGS[i] & MASK_DB[i];
        end
        else if (frame_end_i && ctrl_q[CTL_COMMIT])
        begin
            for (int i = 0; i < NUM_DB; i++)
                act_q[i] <= proc_q[i];
        end
    end

    // Pixel throughput monitor; wraps silently at full scale
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || soft_rst || fsr_done)
            pix_q <= '0;
        else if (HAS_DEBUG && pixel_done_i)
            pix_q <= pix_q + 32'h00000001;
    end

    // Reset into core side; first stage feeds only the second
    // two-flop resync
    always_ff @(posedge sys_clk_i)
    begin
        rsync_q <= {rsync_q[RST_SYNC_STAGES-2:0], rst_i};
    end

    // Core reset from lite reset, immediate and frame-sync soft resets
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            core_rst_q <= 1'b1;
        else
            core_rst_q <= rsync_q[RST_SYNC_STAGES-1] | soft_rst | fsr_done;
    end

    // Outputs straight from flops, except both response codes tied to OKAY
    // enable needs no frame sync
    assign software_enable_o = ctrl_q[CTL_ENABLE];
    assign bypass_o = ctrl_q[CTL_BYPASS];
    assign test_pattern_o = ctrl_q[CTL_TPG];
    assign core_reset_o = core_rst_q;
    assign s_axi_awready_o = wrdy_q;
    assign s_axi_wready_o = wrdy_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = RESP_OKAY;
    assign s_axi_rresp_o = RESP_OKAY;
    assign s_axi_arready_o = ardy_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign frame_dimensions_o = act_q[IDX_FRAME];
    assign output_upper_limit_o = act_q[IDX_UPPER][LIMIT_W-1:0];
    assign output_lower_limit_o = act_q[IDX_LOWER][LIMIT_W-1:0];
    assign red_offset_o = act_q[IDX_ROFS];
    assign green_offset_o = act_q[IDX_GOFS];
    assign blue_offset_o = act_q[IDX_BOFS];
    assign matrix_coef_first_o = act_q[IDX_COEF_A][COEF_W-1:0];
    assign matrix_coef_second_o = act_q[IDX_COEF_B][COEF_W-1:0];
    assign matrix_coef_third_o = act_q[IDX_COEF_C][COEF_W-1:0];
    assign matrix_coef_fourth_o = act_q[IDX_COEF_D][COEF_W-1:0];

    // Checks on the bank's own behaviour
    default clocking cb @(posedge sys_clk_i);
    endclocking

    sequence s_rst_release;
        rst_i [*2] ##1 !rst_i;
    endsequence

    sequence s_wr_req;
        wst_q == CH_IDLE && s_axi_aclken_i && s_axi_awvalid_i
            && s_axi_wvalid_i;
    endsequence

    sequence s_idle_fsync;
        ctrl_q[CTL_FSYNC_RST] && !frame_busy_i && !ctrl_hit;
    endsequence

    AST_WR_ACCEPT: assert property (disable iff (rst_i)
        s_wr_req |=> wrdy_q ##1 (bvalid_q || !$past(s_axi_aclken_i)))
    else $error("write not accepted in time");

    AST_FREEZE: assert property (disable iff (rst_i)
        !s_axi_aclken_i |=> $stable({wrdy_q, bvalid_q, ardy_q, rvalid_q})
            && $stable(rdata_q))
    else $error("lite state moved while enable low");

    AST_RESET_WINS: assert property (
        rst_i |=> !bvalid_q && !rvalid_q && !ctrl_q[CTL_SRESET]
            && !ctrl_q[CTL_FSYNC_RST])
    else $error("lite reset did not act at next edge");

    AST_CORE_RST: assert property (
        s_rst_release |=> core_rst_q [*2])
    else $error("core reset not stretched after release");

    AST_DISABLE: assert property (disable iff (rst_i)
        ctrl_hit && !s_axi_wdata_i[CTL_ENABLE] |=> !software_enable_o)
    else $error("enable not cleared by write");

    AST_COMMIT: assert property (disable iff (rst_i)
        frame_end_i && ctrl_q[CTL_COMMIT] && !soft_rst
            |=> act_q[IDX_FRAME] == $past(proc_q[IDX_FRAME]))
    else $error("active set not copied at frame end");

    AST_HOLD: assert property (disable iff (rst_i)
        !frame_end_i && !soft_rst |=> $stable(act_q[IDX_COEF_A]))
    else $error("active set changed outside frame end");

    AST_SRESET: assert property (disable iff (rst_i)
        soft_rst |=> core_rst_q && pix_q == '0
            && act_q[IDX_FRAME] == (DEF_REGS[IDX_FRAME] & MASK_DB[IDX_FRAME]))
    else $error("soft reset did not hold defaults");

    AST_FSYNC: assert property (disable iff (rst_i)
        s_idle_fsync |=> !ctrl_q[CTL_FSYNC_RST] && core_rst_q)
    else $error("frame-sync reset not done between frames");

    AST_UNMAPPED: assert property (disable iff (rst_i)
        rd_fire && !rd_mapped |=> rvalid_q && s_axi_rdata_o == '0
            && s_axi_rresp_o == RESP_OKAY)
    else $error("unmapped read not zero okay");
endmodule

// ==== tb/ccr_lite_master.sv ====
// Lite-port master model facing the control bank.
// Assumes its tasks are called at a falling clock edge.
module ccr_lite_master
    import ccr_pkg::*;
(
    input wire logic sys_clk_i,
    output logic awvalid_o,
    output logic [31:0] awaddr_o,
    output logic wvalid_o,
    output logic [31:0] wdata_o,
    input wire logic awready_i,
    input wire logic wready_i,
    input wire logic bvalid_i,
    input wire logic [1:0] bresp_i,
    output logic bready_o,
    output logic arvalid_o,
    output logic [31:0] araddr_o,
    input wire logic arready_i,
    input wire logic rvalid_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    output logic rready_o,
    output logic stall_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus; address lines need not be zero
    initial
    begin
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
        {awaddr_o, wdata_o, araddr_o} = '0;
        stall_o = 1'b0;
    end

    // Bounded wait, flags a hang instead of blocking
    task automatic step(inout int n);
        @(negedge sys_clk_i);
        n++;
        if (n > 64)
            stall_o = 1'b1;
    endtask

    task automatic write_word(input logic [31:0] a, input logic [31:0] d,
        output logic [1:0] resp);
        int n;
        n = 0;
        awaddr_o = a;
        wdata_o = d;
        awvalid_o = 1'b1;
        wvalid_o = 1'b1;
        while (!(awready_i && wready_i) && n <= 64)
            step(n);
        @(negedge sys_clk_i);
        awvalid_o = 1'b0;
        wvalid_o = 1'b0;
        // Released lines show no stale value
        awaddr_o = ~a;
        wdata_o = ~d;
        bready_o = 1'b1;
        while (!bvalid_i && n <= 64)
            step(n);
        resp = bresp_i;
        @(negedge sys_clk_i);
        bready_o = 1'b0;
    endtask

    task automatic read_word(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        int n;
        n = 0;
        araddr_o = a;
        arvalid_o = 1'b1;
        while (!arready_i && n <= 64)
            step(n);
        @(negedge sys_clk_i);
        arvalid_o = 1'b0;
        araddr_o = ~a;
        rready_o = 1'b1;
        while (!rvalid_i && n <= 64)
            step(n);
        d = rdata_i;
        resp = rresp_i;
        @(negedge sys_clk_i);
        rready_o = 1'b0;
    endtask
endmodule

// ==== tb/ccr_control_regs_test.sv ====
// Self-checking bench for the converter control register bank.
// Assumes the lite master model and one 125 MHz clock.
module ccr_control_regs_test
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Set before time zero, so no falling edge is seen at start
    logic clk = 1'b0;
    logic rst, aclken, fend, fbusy, pdone;
    logic awv, wv, awr, wr, bv, br, arv, arr, rv, rr, stall;
    logic [31:0] awa, wd, ara, rd_q, fdim, rofs, gofs, bofs;
    logic [1:0] bresp, rresp;
    logic core_rst, sw_en, bypass, tpg;
    logic [15:0] upper, lower;
    logic [17:0] ca, cb, cc, cd;
    int fail_count, total_checks, cycles;

    ccr_control_regs u_ccr_control_regs (.sys_clk_i(clk), .rst_i(rst),
        .s_axi_aclken_i(aclken), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rr), .s_axi_rdata_o(rd_q), .s_axi_rresp_o(rresp),
        .frame_end_i(fend), .frame_busy_i(fbusy), .pixel_done_i(pdone),
        .core_reset_o(core_rst), .software_enable_o(sw_en),
        .bypass_o(bypass), .test_pattern_o(tpg),
        .frame_dimensions_o(fdim), .output_upper_limit_o(upper),
        .output_lower_limit_o(lower), .red_offset_o(rofs),
        .green_offset_o(gofs), .blue_offset_o(bofs),
        .matrix_coef_first_o(ca), .matrix_coef_second_o(cb),
        .matrix_coef_third_o(cc), .matrix_coef_fourth_o(cd));

    ccr_lite_master u_ccr_lite_master (.sys_clk_i(clk), .awvalid_o(awv),
        .awaddr_o(awa), .wvalid_o(wv), .wdata_o(wd), .awready_i(awr),
        .wready_i(wr), .bvalid_i(bv), .bresp_i(bresp), .bready_o(br),
        .arvalid_o(arv), .araddr_o(ara), .arready_i(arr), .rvalid_i(rv),
        .rdata_i(rd_q), .rresp_i(rresp), .rready_o(rr), .stall_o(stall));

    // 8 ns clock
    initial
    begin
        forever #4 clk = ~clk;
    end

    // Hang guard, well above the whole sequence
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask

    // Active set as one word per index
    function automatic logic [31:0] act(input int i);
        logic [31:0] v [NUM_DB];
        v = '{fdim, {16'h0, upper}, {16'h0, lower}, rofs, gofs, bofs,
            {14'h0, ca}, {14'h0, cb}, {14'h0, cc}, {14'h0, cd}};
        return v[i];
    endfunction

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_ccr_lite_master.write_word(a, d, r);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        u_ccr_lite_master.read_word(a, d, r);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
        chk("rdata", e, d);
    endtask

    task automatic cycles_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic frame_pulse();
        fend = 1'b1;
        @(negedge clk);
        fend = 1'b0;
        @(negedge clk);
    endtask

    task automatic act_chk(input logic commit_seen);
        for (int i = 0; i < NUM_DB; i++)
            chk("active", commit_seen ? ((32'hA5C3F00F ^ i) & MASK_DB[i])
                : (DEF_DB[i] & MASK_DB[i]), act(i));
    endtask

    task automatic t_reset_state();
        chk("core_rst held", 32'h1, {31'h0, core_rst});
        cycles_n(4);
        chk("core_rst free", 32'h0, {31'h0, core_rst});
        chk("sw_en", 32'h0, {31'h0, sw_en});
        rd_chk(32'h0, 32'h0);
        act_chk(1'b0);
    endtask

    task automatic t_double_buffer();
        for (int i = 0; i < NUM_DB; i++)
            wr_reg({20'h0, OFS_DB[i]}, 32'hA5C3F00F ^ i);
        for (int i = 0; i < NUM_DB; i++)
            rd_chk({20'h0, OFS_DB[i]}, (32'hA5C3F00F ^ i) & MASK_DB[i]);
        frame_pulse();
        act_chk(1'b0);
        wr_reg(32'h0, 32'h2);
        act_chk(1'b0);
        frame_pulse();
        act_chk(1'b1);
    endtask

    task automatic t_enable_bits();
        wr_reg(32'h0, 32'h33);
        chk("ctl bits", 32'h7, {29'h0, sw_en, bypass, tpg});
        wr_reg(32'h0, 32'h2);
        chk("ctl bits", 32'h0, {29'h0, sw_en, bypass, tpg});
        rd_chk(32'h0, 32'h2);
    endtask

    task automatic t_unmapped_and_count();
        wr_reg(32'h4, 32'hFFFFFFFF);
        rd_chk(32'h4, 32'h0);
        pdone = 1'b1;
        cycles_n(3);
        pdone = 1'b0;
        rd_chk({20'h0, OFS_PIXEL_COUNT}, 32'h3);
    endtask

    task automatic t_soft_resets();
        int seen;
        fbusy = 1'b1;
        wr_reg(32'h0, 32'h40000002);
        rd_chk(32'h0, 32'h40000002);
        fbusy = 1'b0;
        fend = 1'b1;
        seen = 0;
        for (int k = 0; k < 6; k++)
        begin
            @(negedge clk);
            fend = 1'b0;
            seen += core_rst;
        end
        // Frame-sync reset is a single core reset cycle
        chk("fsync pulse", 32'h1, seen);
        rd_chk(32'h0, 32'h2);
        rd_chk({20'h0, OFS_PIXEL_COUNT}, 32'h0);
        // Between frames the bit acts and clears at once
        wr_reg(32'h0, 32'h40000002);
        rd_chk(32'h0, 32'h2);
        wr_reg(32'h0, 32'h80000000);
        cycles_n(3);
        chk("sreset core", 32'h1, {31'h0, core_rst});
        act_chk(1'b0);
        rd_chk(32'h20, DEF_DB[IDX_FRAME]);
        wr_reg(32'h0, 32'h0);
        cycles_n(4);
        chk("sreset off", 32'h0, {31'h0, core_rst});
    endtask

    task automatic t_freeze();
        aclken = 1'b0;
        fork
            wr_reg(32'h100, 32'h1234);
            begin
                for (int k = 0; k < 6; k++)
                begin
                    @(negedge clk);
                    chk("frozen ready", 32'h0, {31'h0, awr});
                end
                aclken = 1'b1;
            end
        join
        rd_chk(32'h100, 32'h1234);
    endtask

    task automatic t_reset_overrides_enable();
        wr_reg(32'h0, 32'h1);
        aclken = 1'b0;
        rst = 1'b1;
        // Full hold the system owes the port
        cycles_n(32);
        rst = 1'b0;
        chk("sw_en rst", 32'h0, {31'h0, sw_en});
        aclken = 1'b1;
        // First request one cycle after the release edge
        cycles_n(1);
        rd_chk(32'h100, DEF_DB[IDX_UPPER]);
        chk("no hang", 32'h0, {31'h0, stall});
    endtask

    // Main sequence
    initial
    begin
        fail_count = 0;
        total_checks = 0;
        cycles = 0;
        {aclken, fend, fbusy, pdone} = 4'b1000;
        rst = 1'b1;
        cycles_n(2);
        rst = 1'b0;
        @(negedge clk);
        t_reset_state();
        t_double_buffer();
        t_enable_bits();
        t_unmapped_and_count();
        t_soft_resets();
        t_freeze();
        t_reset_overrides_enable();
        final_report();
    end
endmodule
